// ===== include/css_map.vh
// Register offsets, reset values and timing constants of the charger start-up sequencer
`ifndef CSS_MAP_VH
`define CSS_MAP_VH

`define CSS_CHG_CUR_OFFSET   8'h14
`define CSS_CTRL2_OFFSET     8'h3D
`define CSS_CTRL3_OFFSET     8'h4C
`define CSS_ADDR_W           8
`define CSS_DATA_W           16
`define CSS_CHG_CUR_LOW      16'h0020
`define CSS_CHG_CUR_ZERO     16'h0000
`define CSS_CTRL2_RESET      16'h0000
`define CSS_CTRL2_DEB_BIT    11
`define CSS_CTRL3_MODE_BIT   7
`define CSS_CLK_HZ           100000000
`define CSS_DEB_LONG_MS      1300
`define CSS_DEB_SHORT_MS     150
`define CSS_CONFIG_RESISTOR_PIN_SETTLE_US   40
// Counts at 100 MHz; debounce and settle counts sized to the 28-bit sequencer timer, short check and gate-on counts to 16 bits
`define CSS_DEB_LONG_CYC     28'h7BFA480
`define CSS_DEB_SHORT_CYC    28'h0E4E1C0
`define CSS_CONFIG_RESISTOR_PIN_SETTLE_CYC  28'h0000FA0
`define CSS_SHORT_CHK_CYC    16'h0100
`define CSS_GATE_ON_CYC      16'h0400

`endif

// ===== rtl/css_charger_startup_sequencer.v
// Start-up sequencer: wake, adapter debounce, short check, switch gate, adapter-good, configuration strap
`timescale 1ns/1ns
`include "css_map.vh"

// Function
// RULE_01 - Core and register port stay inactive until bias supply passes wake level.
// RULE_02 - Later insertions debounce long or short per second control word bit 11.
// RULE_03 - First insertion after power-up always uses the short debounce.
// RULE_04 - After debounce, short check blocks gate if sense node or adapter sense low.
// RULE_05 - Adapter present, then debounce, then short check, then gate enabling.
// RULE_06 - Adapter-good released only with bias high, adapter sense high, gate fully on.
// RULE_07 - Converter switching starts only once adapter-good is asserted.
// RULE_08 - Adapter-good driven low whenever no adapter is detected.
// RULE_09 - Source test current into config pin and capture it before gate enable.
// RULE_10 - Battery only with no adapter puts the device in low power.
// RULE_11 - Topology pin high selects charge-only; low selects system-regulating mode.
// RULE_12 - Topology high at reset: low current code, host-controlled charging mode bit.
// RULE_13 - Charge-only mode runs no host-communication timeout.
// RULE_14 - Zero charge-current register disables the charge current limit.
// RULE_15 - Topology low at reset: current zero, battery FET off, voltage loop at max.
// RULE_16 - System mode charging begins only after nonzero charge-current write.
// RULE_17 - Reverse-block mode turns low-side gate off at zero phase voltage.
// RULE_18 - On-pulse ends at upper window level; next starts at compensation level.
// RULE_19 - Adapter loss during debounce or short check aborts and keeps gate off.
// RULE_20 - Debounce timed by clock counter with terminal counts matching durations.
module css_charger_startup_sequencer #(
  parameter [27:0] DEB_LONG_CYC  = `CSS_DEB_LONG_CYC,
  parameter [27:0] DEB_SHORT_CYC = `CSS_DEB_SHORT_CYC
) (
  input  wire        clk_sys,
  input  wire        rst_b,
  // Bias and adapter comparators
  input  wire        biasWake,
  input  wire        biasUpper,
  input  wire        adapterVoltagePresent,
  input  wire        adapterSenseInput,
  input  wire        inputCurrentSensePosOk,
  input  wire        adapterSenseShortOk,
  input  wire        adapterSwitchGateFull,
  // Straps and battery
  input  wire        topologySelectPin,
  input  wire        batteryPresent,
  input  wire [7:0]  configResistorAdc,
  // Modulator comparators
  input  wire        rippleAtUpperWindow,
  input  wire        rippleAtComp,
  input  wire        phaseZero,
  // Register port
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [7:0]  regAddr,
  input  wire [15:0] regWdata,
  output reg  [15:0] regRdata,
  output reg         regReady,
  // Gate, flag and configuration pins
  output reg         adapterSwitchGate,
  output reg         adapterGoodFlagOut,
  output reg         adapterGoodFlagOe,
  output reg         configSourceEn,
  output reg  [7:0]  configCapture,
  output reg         switchingEn,
  output reg         pwmOn,
  output reg         lowSideGate,
  // Charging mode
  output reg         batterySwitchFet,
  output reg         constantVoltageLoop,
  output reg         chargeEnable,
  output reg         chargeLimitEn,
  output reg         narrowRangeSystemCharging,
  output reg         hostTimeoutEn,
  output reg         lowPower
);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_DEB    = 3'd1;
  localparam [2:0] ST_CONFIG_RESISTOR_PIN   = 3'd2;
  localparam [2:0] ST_SHORT  = 3'd3;
  localparam [2:0] ST_GATE   = 3'd4;
  localparam [2:0] ST_RUN    = 3'd5;

  localparam [27:0] CONFIG_RESISTOR_PIN_CYC  = `CSS_CONFIG_RESISTOR_PIN_SETTLE_CYC;
  localparam [27:0] SHORT_CYC = {12'h000, `CSS_SHORT_CHK_CYC};

  localparam [1:0] REG_CHG_CUR = 2'h0;
  localparam [1:0] REG_CTRL2   = 2'h1;
  localparam [1:0] REG_CTRL3   = 2'h2;
  localparam [1:0] REG_NONE    = 2'h3;

  reg [2:0]  state_reg;
  reg [27:0] timer_reg;
  reg        firstDone_reg;
  reg        strapped_reg;
  reg        chargeOnly_reg;
  reg        hostWrote_reg;
  reg [15:0] chgCur_reg;
  reg [15:0] ctrl2_reg;
  reg [15:0] ctrl3_reg;
  // No control bit for reverse blocking here; held on from reset
  reg        reverseBlockMode_reg;

  wire coreAwake  = biasWake;
  wire adapterIn  = adapterVoltagePresent;
  // Last count reached: debounce and settle last exactly their loaded number of cycles, short check at least
  wire timerDone  = (timer_reg <= 28'h0000001);
  wire goodCond   = biasUpper & adapterSenseInput & adapterSwitchGateFull;

  // Debounce length: first insertion short, later per control bit
  function [27:0] debLen;
    input first;
    input sel;
    begin
      debLen = (first | ~sel) ? DEB_SHORT_CYC : DEB_LONG_CYC; // [RULE_02] [RULE_03]
    end
  endfunction

  // Register address decode shared by the write and read paths
  function [1:0] regIndex;
    input [7:0] addr;
    begin
      case (addr)
        `CSS_CHG_CUR_OFFSET: regIndex = REG_CHG_CUR;
        `CSS_CTRL2_OFFSET:   regIndex = REG_CTRL2;
        `CSS_CTRL3_OFFSET:   regIndex = REG_CTRL3;
        default:             regIndex = REG_NONE;
      endcase
    end
  endfunction

  wire [1:0] regSel = regIndex(regAddr);

  // ----------------------------------------------------------------
  // Start-up sequence
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b || !coreAwake) begin
      state_reg          <= ST_IDLE; // [RULE_01]
      timer_reg          <= 28'h0000000;
      adapterSwitchGate  <= 1'b0;
      configSourceEn     <= 1'b0;
      configCapture      <= 8'h00;
      adapterGoodFlagOut <= 1'b0;
      adapterGoodFlagOe  <= 1'b1;
      switchingEn        <= 1'b0;
      lowPower           <= 1'b0;
      if (!rst_b)
        firstDone_reg <= 1'b0;
    end else begin
      lowPower <= batteryPresent & ~adapterIn; // [RULE_10]
      if (timer_reg != 28'h0000000)
        timer_reg <= timer_reg - 28'h0000001; // [RULE_20]
      // Open drain: pulled low unless all readiness conditions hold
      adapterGoodFlagOe <= ~(adapterIn && state_reg == ST_RUN && goodCond); // [RULE_06] [RULE_08]
      switchingEn       <= adapterIn && state_reg == ST_RUN && goodCond && !adapterGoodFlagOe; // [RULE_07]
      if (!adapterIn && state_reg != ST_IDLE) begin
        state_reg         <= ST_IDLE; // [RULE_19]
        adapterSwitchGate <= 1'b0;
        configSourceEn    <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (adapterIn) begin
              state_reg <= ST_DEB; // [RULE_05]
              timer_reg <= debLen(~firstDone_reg, ctrl2_reg[`CSS_CTRL2_DEB_BIT]);
            end
          end
          ST_DEB: begin
            if (timerDone) begin
              firstDone_reg  <= 1'b1;
              state_reg      <= ST_CONFIG_RESISTOR_PIN;
              configSourceEn <= 1'b1; // [RULE_09]
              timer_reg      <= CONFIG_RESISTOR_PIN_CYC;
            end
          end
          ST_CONFIG_RESISTOR_PIN: begin
            if (timerDone) begin
              configCapture  <= configResistorAdc; // [RULE_09]
              configSourceEn <= 1'b0;
              state_reg      <= ST_SHORT;
              timer_reg      <= SHORT_CYC;
            end
          end
          ST_SHORT: begin
            // Short on the input bus: hold the gate off and stay here
            if (timerDone && inputCurrentSensePosOk && adapterSenseShortOk) begin
              state_reg         <= ST_GATE; // [RULE_04] [RULE_05]
              adapterSwitchGate <= 1'b1;
            end
          end
          ST_GATE: begin
            if (adapterSwitchGateFull)
              state_reg <= ST_RUN;
          end
          ST_RUN: begin
            state_reg <= ST_RUN;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Strap capture and registers
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      strapped_reg         <= 1'b0;
      chargeOnly_reg       <= 1'b0;
      hostWrote_reg        <= 1'b0;
      chgCur_reg           <= `CSS_CHG_CUR_ZERO;
      ctrl2_reg            <= `CSS_CTRL2_RESET;
      ctrl3_reg            <= 16'h0000;
      reverseBlockMode_reg <= 1'b1;
      regRdata             <= 16'h0000;
      regReady             <= 1'b0;
    end else if (coreAwake) begin
      // No answer on the strap clock, a write is not taken there though a read still loads regRdata
      regReady <= (regWrite | regRead) & strapped_reg; // [RULE_01]
      if (!strapped_reg) begin
        // Strap caught on the first awake clock after reset
        strapped_reg   <= 1'b1;
        chargeOnly_reg <= topologySelectPin; // [RULE_11]
        if (topologySelectPin) begin
          chgCur_reg <= `CSS_CHG_CUR_LOW; // [RULE_12]
          ctrl3_reg  <= 16'h0001 << `CSS_CTRL3_MODE_BIT;
        end else begin
          chgCur_reg <= `CSS_CHG_CUR_ZERO; // [RULE_15]
        end
      end else if (regWrite) begin
        case (regSel)
          REG_CHG_CUR: begin
            chgCur_reg    <= regWdata;
            hostWrote_reg <= (regWdata != 16'h0000); // [RULE_16]
          end
          REG_CTRL2: ctrl2_reg <= regWdata;
          REG_CTRL3: ctrl3_reg <= regWdata;
          default: ctrl3_reg <= ctrl3_reg;
        endcase
      end
      if (regRead) begin
        case (regSel)
          REG_CHG_CUR: regRdata <= chgCur_reg;
          REG_CTRL2:   regRdata <= ctrl2_reg;
          REG_CTRL3:   regRdata <= ctrl3_reg;
          default:             regRdata <= 16'h0000;
        endcase
      end
    end else begin
      regReady <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Charging mode outputs
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      batterySwitchFet          <= 1'b0;
      constantVoltageLoop       <= 1'b1;
      chargeEnable              <= 1'b0;
      chargeLimitEn             <= 1'b0;
      narrowRangeSystemCharging <= 1'b0;
      hostTimeoutEn             <= 1'b0;
    end else begin
      narrowRangeSystemCharging <= strapped_reg & ~chargeOnly_reg; // [RULE_11]
      hostTimeoutEn             <= strapped_reg & ~chargeOnly_reg; // [RULE_13]
      chargeLimitEn             <= (chgCur_reg != 16'h0000); // [RULE_14]
      if (chargeOnly_reg) begin
        batterySwitchFet    <= 1'b0;
        constantVoltageLoop <= 1'b0;
        chargeEnable        <= strapped_reg;
      end else begin
        // Battery FET off and voltage loop at upper setpoint until host asks
        batterySwitchFet    <= hostWrote_reg; // [RULE_15] [RULE_16]
        constantVoltageLoop <= ~hostWrote_reg;
        chargeEnable        <= hostWrote_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Modulator pulse and reverse blocking
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b || !switchingEn) begin
      pwmOn       <= 1'b0;
      lowSideGate <= 1'b0;
    end else begin
      if (pwmOn && rippleAtUpperWindow)
        pwmOn <= 1'b0; // [RULE_18]
      else if (!pwmOn && rippleAtComp)
        pwmOn <= 1'b1; // [RULE_18]
      if (pwmOn && rippleAtUpperWindow)
        lowSideGate <= 1'b1;
      else if (pwmOn || (reverseBlockMode_reg && phaseZero))
        lowSideGate <= 1'b0; // [RULE_17]
    end
  end

endmodule // css_charger_startup_sequencer

// ===== sim/css_checker.sv
// Port assertions for the charger start-up sequencer
`timescale 1ns/1ns
module css_checker (
  input wire clk_sys,
  input wire rst_b,
  input wire biasWake,
  input wire biasUpper,
  input wire adapterVoltagePresent,
  input wire adapterSenseInput,
  input wire inputCurrentSensePosOk,
  input wire adapterSenseShortOk,
  input wire adapterSwitchGateFull,
  input wire regWrite,
  input wire regRead,
  input wire regReady,
  input wire adapterSwitchGate,
  input wire adapterGoodFlagOe,
  input wire configSourceEn,
  input wire switchingEn,
  input wire pwmOn,
  input wire lowSideGate,
  input wire rippleAtUpperWindow,
  input wire phaseZero
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  cfg_gate_off_a:
    assert property (configSourceEn |-> !adapterSwitchGate) else $error("gate on while config current on");
  short_check_a:
    assert property ($rose(adapterSwitchGate) |-> $past(inputCurrentSensePosOk && adapterSenseShortOk))
      else $error("gate on despite failed short check");
  good_release_a:
    assert property (!adapterGoodFlagOe |-> $past(biasUpper && adapterSenseInput && adapterSwitchGateFull))
      else $error("adapter-good released early");
  switch_gated_a:
    assert property (switchingEn |-> !$past(adapterGoodFlagOe)) else $error("switching without adapter-good");
  switch_start_a:
    assert property ($fell(adapterGoodFlagOe) |=> switchingEn) else $error("switching did not start");
  no_adapter_a:
    assert property (!adapterSenseInput |=> adapterGoodFlagOe) else $error("adapter-good not pulled low");
  abort_gate_a:
    assert property (!adapterVoltagePresent |-> ##[1:2] !adapterSwitchGate) else $error("gate stays on");
  reg_answer_a:
    assert property (regReady |-> $past(biasWake && (regWrite || regRead))) else $error("stray ready");
  reverse_block_a:
    assert property (phaseZero |=> !lowSideGate) else $error("low-side gate on at zero phase");
  pulse_end_a:
    assert property (rippleAtUpperWindow |=> !pwmOn) else $error("on-pulse not ended");
endmodule // css_checker

// ===== sim/css_front_end_model.sv
// Analogue front-end and power-stage model facing the sequencer
`timescale 1ns/1ns
module css_front_end_model (
  input  wire  clk_sys,
  input  wire  adapterOn,
  input  wire  shortOk,
  input  wire  adapterSwitchGate,
  input  wire  pwmOn,
  input  wire  lowSideGate,
  output logic adapterVoltagePresent,
  output logic adapterSenseInput,
  output logic inputCurrentSensePosOk,
  output logic adapterSenseShortOk,
  output logic adapterSwitchGateFull,
  output logic rippleAtUpperWindow,
  output logic rippleAtComp,
  output logic phaseZero
);
  logic [3:0] gateAge = 4'h0;
  logic [3:0] ripple = 4'h0;
  initial {adapterVoltagePresent, adapterSenseInput, inputCurrentSensePosOk, adapterSenseShortOk} = 4'h0;
  initial {adapterSwitchGateFull, rippleAtUpperWindow, rippleAtComp, phaseZero} = 4'h0;
  always @(posedge clk_sys) begin
    adapterVoltagePresent <= adapterOn;
    adapterSenseInput <= adapterOn;
    inputCurrentSensePosOk <= adapterOn & shortOk;
    adapterSenseShortOk <= adapterOn;
    // Gate needs a few cycles to enhance fully
    gateAge <= adapterSwitchGate ? gateAge + {3'h0, gateAge != 4'hF} : 4'h0;
    adapterSwitchGateFull <= gateAge > 4'h2;
    ripple <= pwmOn ? ripple + 4'h1 : ripple - {3'h0, ripple != 4'h0};
    rippleAtUpperWindow <= pwmOn && ripple > 4'h5;
    rippleAtComp <= !pwmOn && ripple < 4'h2;
    phaseZero <= lowSideGate && ripple < 4'h3;
  end
endmodule // css_front_end_model

// ===== sim/test_charger_startup_sequencer.sv
// Self-checking bench for the charger start-up sequencer
`timescale 1ns/1ns
`include "css_map.vh"
module test_charger_startup_sequencer;
  logic clk_sys = 1'b0, rst_b = 1'b0, biasWake = 1'b1, biasUpper = 1'b1, topologySelectPin = 1'b1;
  logic batteryPresent = 1'b1, adapterOn = 1'b0, shortOk = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00, configResistorAdc = 8'h00;
  logic [15:0] regWdata = 16'h0000, v;
  wire [15:0] regRdata;
  wire [7:0] configCapture;
  wire adapterVoltagePresent, adapterSenseInput, inputCurrentSensePosOk, adapterSenseShortOk, adapterSwitchGateFull;
  wire rippleAtUpperWindow, rippleAtComp, phaseZero, regReady, adapterSwitchGate, adapterGoodFlagOut;
  wire adapterGoodFlagOe, configSourceEn, switchingEn, pwmOn, lowSideGate, batterySwitchFet, constantVoltageLoop;
  wire chargeEnable, chargeLimitEn, narrowRangeSystemCharging, hostTimeoutEn, lowPower;
  wire [3:0] mon = {switchingEn, adapterGoodFlagOe, adapterSwitchGate, configSourceEn};
  int seed = 4, failures = 0, tests_run = 0, d1, d2;
  logic [15:0] regModel [int];
  css_charger_startup_sequencer #(.DEB_LONG_CYC(28'd50), .DEB_SHORT_CYC(28'd20)) i_css_charger_startup_sequencer (.*);
  css_front_end_model i_css_front_end_model (.*);
  always #5 clk_sys = ~clk_sys;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic rdy);
    @(posedge clk_sys);
    {regWrite, regRead, regAddr, regWdata} <= {wr, !wr, a, d};
    @(posedge clk_sys);
    {regWrite, regRead} <= 2'b00;
    @(posedge clk_sys);
    check(regReady, rdy);
    if (wr && regModel.exists(a)) regModel[a] = d;
  endtask
  task automatic waitBit(input int b, input logic lvl, output int n);
    n = 0;
    while (mon[b] !== lvl && n < 9000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic plug(input logic ok, output int deb);
    int n, m;
    @(posedge clk_sys);
    {configResistorAdc, shortOk, adapterOn} <= {8'($random(seed)), ok, 1'b1};
    waitBit(0, 1'b1, deb);
    waitBit(0, 1'b0, n);
    check(n[15:0], 16'd4000);
    check({8'h00, configCapture}, {8'h00, configResistorAdc});
    waitBit(1, 1'b1, n);
    check(n >= 256 && n <= 262, ok);
    waitBit(3, 1'b1, n);
    check({adapterGoodFlagOe, switchingEn, adapterGoodFlagOut, lowPower}, {!ok, ok, 2'b00});
    n = 0;
    m = 0;
    repeat (60) begin
      @(posedge clk_sys);
      n += pwmOn;
      m += lowSideGate;
    end
    check({n != 0, m != 0}, {ok, ok});
  endtask
  task automatic unplug();
    @(posedge clk_sys);
    adapterOn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check({adapterGoodFlagOe, adapterSwitchGate, lowPower}, 3'b101);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    regModel[8'h14] = `CSS_CHG_CUR_LOW;
    access(1'b0, 8'h14, 16'h0000, 1'b1);
    check(regRdata, regModel[8'h14]);
    access(1'b0, 8'h4C, 16'h0000, 1'b1);
    check({regRdata[7], chargeEnable, chargeLimitEn, narrowRangeSystemCharging, hostTimeoutEn}, 5'b11100);
    access(1'b0, 8'h77, 16'h0000, 1'b1);
    check(regRdata, 16'h0000);
    access(1'b1, 8'h3D, 16'h0800, 1'b1);
    plug(1'b1, d1);
    check(d1 >= 20 && d1 <= 23, 1'b1);
    unplug();
    plug(1'b1, d2);
    check(d2[15:0] - d1[15:0], 16'd30);
    unplug();
    access(1'b1, 8'h3D, 16'h0000, 1'b1);
    @(posedge clk_sys);
    adapterOn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    unplug();
    plug(1'b1, d2);
    check(d2[15:0], d1[15:0]);
    unplug();
    plug(1'b0, d2);
    unplug();
    $display("test adapter sequence done");
    {rst_b, topologySelectPin} <= 2'b00;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    regModel[8'h14] = `CSS_CHG_CUR_ZERO;
    access(1'b0, 8'h14, 16'h0000, 1'b1);
    check(regRdata, regModel[8'h14]);
    check({batterySwitchFet, constantVoltageLoop, chargeEnable, narrowRangeSystemCharging, hostTimeoutEn, chargeLimitEn},
          6'b010110);
    v = 16'($random(seed)) | 16'h0001;
    access(1'b1, 8'h14, v, 1'b1);
    access(1'b0, 8'h14, 16'h0000, 1'b1);
    check(regRdata, regModel[8'h14]);
    check({chargeEnable, chargeLimitEn, batterySwitchFet, constantVoltageLoop}, 4'b1110);
    access(1'b1, 8'h14, 16'h0000, 1'b1);
    @(posedge clk_sys);
    check({chargeEnable, chargeLimitEn, batterySwitchFet, constantVoltageLoop}, 4'b0001);
    biasWake <= 1'b0;
    access(1'b0, 8'h14, 16'h0000, 1'b0);
    $display("test configuration done");
    print_verdict();
  end
endmodule // test_charger_startup_sequencer
bind css_charger_startup_sequencer css_checker i_css_checker (.*);
